/* File: bench/tta_sig_model.sv */
// Purpose: Far-side model of the external trigger input and the aux pin
// Assumes: Stepped from the bench clock; codes unsigned, 0x80 is zero volts
// Notes: Aux wire takes the block's drive while enabled, else the model's level
`timescale 1ns/1ps
module tta_sig_model (
	input wire logic ref_clk_in,
	input wire logic fire_in,
	input wire logic level_in,
	input wire logic aux_drv_in,
	input wire logic aux_oe_in,
	output logic [7:0] ext_code_out,
	output logic aux_wire_out
);
	// ----------------------------------------
	// Trigger pulse
	// ----------------------------------------
	logic [2:0] len_r = 3'h0;
	// Pulse crosses zero volts upward, then back down, so both slopes see one edge
	always_ff @(posedge ref_clk_in)
	begin
		if (fire_in)
			len_r <= 3'h4;
		else if (len_r != 3'h0)
			len_r <= len_r - 3'h1;
	end
	assign ext_code_out = (len_r != 3'h0) ? 8'hc0 : 8'h40;
	// Wire level: never the stale value, the far side owns it when not driven
	assign aux_wire_out = aux_oe_in ? aux_drv_in : level_in;
endmodule

/* File: bench/tta_top_test.sv */
// Purpose: Self-checking bench for the trigger timing and aux block
// Assumes: 200 MHz clock, AXI4-Lite master driven at rising edges
// Notes: Expected values come from a small register model and rule arithmetic
`timescale 1ns/1ps
module tta_top_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic fire = 1'b0, lvl = 1'b0, ce = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, ch_a = 8'h00, ext;
	logic [31:0] wdata = 32'h0000_0000, rdata, rv;
	logic awready, wready, bvalid, arready, rvalid, aux_o, aux_oe, trig, rec, aux_w;
	logic [1:0] bresp, rresp, pack, rs;
	logic [31:0] mdl [7] = '{32'h8080_0000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	int errors = 0, comparisons = 0, seed = 32'h9f34ccd2, n, d, ntrig;
	// Clock, random channel A codes, trigger counter
	always #2.5 clk = ~clk;
	always @(posedge clk) ch_a <= 8'($random(seed));
	always @(negedge clk) if (trig === 1'b1) ntrig++;
	tta_top dut (.ref_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.external_trigger_input_in(ext), .ch_a_code_in(ch_a), .aux_in(aux_w), .aux_out(aux_o),
		.aux_oe_out(aux_oe), .trigger_out(trig), .record_start_out(rec), .sample_packing_select_out(pack));
	tta_sig_model far (.ref_clk_in(clk), .fire_in(fire), .level_in(lvl), .aux_drv_in(aux_o),
		.aux_oe_in(aux_oe), .ext_code_out(ext), .aux_wire_out(aux_w));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		@(posedge clk);
		awaddr <= a;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// Gap covers the longest delay plus capture
	task automatic pulse;
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (30) @(posedge clk);
	endtask
	// Watchdog: whole plan is well under this span
	initial
	begin
		repeat (30000) @(posedge clk);
		errors++;
		print_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			rd(8'(i * 4));
			chk("reset value", rv, mdl[i]);
		end
		chk("aux enable", aux_oe, 1);
		chk("packing", pack, tta_pkg::packing_sixteen_bit);
		rd(8'h1c);
		chk("unmapped", rs, tta_pkg::RESP_SLVERR);
		wr(8'h18, 32'hffff_ffff);
		chk("status write", rs, tta_pkg::RESP_SLVERR);
		// Each combine op, external source, random delay
		for (int op = 0; op < 3; op++)
		begin
			d = {$random(seed)} % 16;
			wr(8'h00, 32'h8080_0000 | op | (op == 0 ? 32'h4 : (op == 1 ? 32'h400 : 32'h1400)));
			wr(8'h08, d);
			wr(8'h14, 32'h1);
			pulse();
			chk("triggers", ntrig, 1 + op);
			ntrig = op + 1;
			wr(8'h14, 32'h0);
		end
		wr(8'h14, 32'h1);
		@(posedge clk) fire <= 1'b1;
		@(posedge clk) fire <= 1'b0;
		do @(negedge clk); while (trig !== 1'b1);
		chk("aux trigger", aux_o, 1);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (rec !== 1'b1);
		chk("record delay", n, d + 1);
		wr(8'h14, 32'h0);
		// Timeout of one unit, then off
		wr(8'h04, 32'h1);
		wr(8'h14, 32'h1);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (trig !== 1'b1);
		chk("timeout span", n, tta_pkg::TICK_CYCLES + 2);
		wr(8'h14, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h14, 32'h1);
		ntrig = 0;
		repeat (2100) @(posedge clk);
		chk("no timeout", ntrig, 0);
		wr(8'h14, 32'h0);
		// Pacer with a legal divider
		d = 3 + {$random(seed)} % 6;
		wr(8'h0c, (d << 16) | 1);
		do @(negedge clk); while (aux_o !== 1'b0);
		do @(negedge clk); while (aux_o !== 1'b1);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (aux_o !== 1'b0);
		chk("pacer high", n, d / 2);
		do
		begin
			@(negedge clk);
			n++;
		end while (aux_o !== 1'b1);
		chk("pacer period", n, d);
		// Clock enable low must freeze the divider
		@(posedge clk) ce <= 1'b0;
		@(negedge clk) rv = aux_o;
		n = 0;
		repeat (6) @(negedge clk) n += (aux_o !== rv[0]);
		chk("frozen pacer", n, 0);
		@(posedge clk) ce <= 1'b1;
		for (int b = 0; b < 2; b++)
		begin
			wr(8'h0c, (b << 16) | 2);
			repeat (2) @(negedge clk);
			chk("static level", aux_o, b);
			@(posedge clk) lvl <= 1'($random(seed));
			wr(8'h0c, 32'h4);
			rd(8'h18);
			chk("level in", rv[0], lvl);
		end
		// Window closed, then one rising aux edge opens two triggers
		@(posedge clk) lvl <= 1'b0;
		wr(8'h0c, 32'h3);
		wr(8'h14, 32'h0002_0001);
		ntrig = 0;
		pulse();
		chk("closed window", ntrig, 0);
		@(posedge clk) lvl <= 1'b1;
		repeat (3) pulse();
		chk("window triggers", ntrig, 2);
		wr(8'h14, 32'h0);
		// Falling-edge window of one record
		wr(8'h0c, 32'h0001_0003);
		wr(8'h14, 32'h0001_0001);
		ntrig = 0;
		@(posedge clk) lvl <= 1'b0;
		repeat (2) pulse();
		chk("falling window", ntrig, 1);
		wr(8'h14, 32'h0);
		// Packing latched at arming only; code 3 falls back to 16-bit
		for (int p = 0; p < 4; p++)
		begin
			wr(8'h10, p);
			wr(8'h14, 32'h1);
			wr(8'h10, (p + 1) % 3);
			chk("packing", pack, p % 3);
			wr(8'h14, 32'h0);
		end
		print_verdict();
	end
endmodule

/* File: verilog/tta_pkg.sv */
// Purpose: Shared constants, types and register map for the trigger timing and aux I/O block
// Assumes: 200 MHz sample clock, AXI4-Lite register access with 32-bit data
// Notes: Every offset, register reset value and cycle count lives here; mode, arm, packing and status bit positions do not
package tta_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned TIMEOUT_UNIT_US = 10;
	localparam int unsigned TICK_CYCLES = TIMEOUT_UNIT_US * CLK_MHZ;
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_TRIG_CFG = 8'h00;
	localparam logic [7:0] OFS_TIMEOUT = 8'h04;
	localparam logic [7:0] OFS_DELAY = 8'h08;
	localparam logic [7:0] OFS_AUX_CFG = 8'h0c;
	localparam logic [7:0] OFS_PACK = 8'h10;
	localparam logic [7:0] OFS_ACQ = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int F_OP_LSB = 0;
	localparam int F_SRC_LSB = 2;
	localparam int F_SLOPE_BIT = 4;
	localparam int F_ENG_STRIDE = 8;
	localparam int F_LVL_LSB = 16;
	localparam int F_PARAM_LSB = 16;
	localparam int F_RPB_LSB = 16;
	localparam logic [31:0] TRIG_CFG_MASK = 32'hffff_1f1f;
	localparam logic [31:0] TRIG_CFG_RST = 32'h8080_0000;
	localparam logic [31:0] AUX_CFG_MASK = 32'hffff_0007;
	localparam logic [31:0] AUX_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] ACQ_MASK = 32'hffff_0001;
	localparam logic [31:0] ZERO_RST = 32'h0000_0000;
	localparam logic [7:0] LEVEL_ZERO_VOLT = 8'h80;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {source_none = 2'h0, source_external_input = 2'h1, source_channel_a = 2'h2} tta_src_e;
	typedef enum logic [1:0] {combine_engine_j = 2'h0, combine_engine_k = 2'h1, combine_either_engine = 2'h2} tta_op_e;
	typedef enum logic [2:0] {aux_mode_trig_out = 3'h0, aux_mode_pacer = 3'h1, aux_mode_static = 3'h2,
		aux_mode_trig_enable = 3'h3, aux_mode_level_in = 3'h4} tta_aux_e;
	typedef enum logic [1:0] {packing_sixteen_bit = 2'h0, packing_eight_bit = 2'h1, packing_twelve_bit = 2'h2} tta_pack_e;
	typedef enum logic [1:0] {st_idle = 2'b00, st_wait = 2'b01, st_delay = 2'b11, st_capt = 2'b10} tta_state_e;

	typedef struct packed {
		tta_src_e src;
		logic slope_neg;
		logic [7:0] level;
	} tta_eng_cfg_s;

endpackage

/* File: verilog/tta_top.sv */
// Purpose: Trigger timeout, delay, aux pin modes and packing select behind AXI4-Lite
// Assumes: Sample clock ref_clk_in at 200 MHz, all pin inputs synchronous to it
// Notes: ce_in low freezes every flip-flop and holds the bus ready signals low
// Summary of operation
// R1: Either engine can take the external trigger input as its source.
// R2: Level is 8-bit unsigned, 128 is zero; slope picks rising or falling crossing.
// R3: Board trigger from engine J, engine K, or either engine.
// R4: No hardware trigger within the timeout interval fires one automatic trigger.
// R5: Timeout counts 10 us units; zero disables it entirely.
// R6: Software should return the timeout to zero once triggering is stable.
// R7: After a trigger, wait the programmed sample clocks before starting capture.
// R8: Trigger-output mode drives the trigger on the aux pin, clock aligned.
// R9: Aux pin powers up in trigger-output mode.
// R10: Pacer mode outputs the sample clock divided by the programmed divider.
// R11: Software keeps the pacer divider above 2.
// R12: Static mode drives the parameter's bit: 0 low, 1 high.
// R13: Trigger-enable mode waits for an aux edge, then accepts one buffer of triggers.
// R14: Level-input mode lets software read the aux pin level.
// R15: Default packing is 16-bit words, one sample each.
// R16: Packing selects 16-bit, packed 8-bit or packed 12-bit.
// R17: Packing is taken when the acquisition is armed; later changes wait.
// R18: Timeout restarts on entering the wait and clears on any hardware trigger.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module tta_top (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [7:0] external_trigger_input_in,
	input wire logic [7:0] ch_a_code_in,
	input wire logic aux_in,
	output logic aux_out,
	output logic aux_oe_out,
	output logic trigger_out,
	output logic record_start_out,
	output logic [1:0] sample_packing_select_out
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic aw_hold_r;
	logic [7:0] aw_addr_r;
	logic w_hold_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;
	logic wr_hit;
	logic [31:0] rd_data;
	logic rd_hit;
	logic [31:0] trig_cfg_r;
	logic [31:0] timeout_r;
	logic [31:0] delay_r;
	logic [31:0] aux_cfg_r;
	logic [1:0] pack_sel_r;
	logic [31:0] acq_r;
	tta_pkg::tta_eng_cfg_s eng_cfg [2];
	logic [1:0] eng_ev;
	tta_pkg::tta_state_e state_r;
	tta_pkg::tta_aux_e aux_mode;
	logic [15:0] aux_param;
	logic armed;
	logic hw_trig;
	logic gate_ok;
	logic hw_ok;
	logic to_fire;
	logic accept;
	logic [11:0] tick_cnt_r;
	logic [31:0] to_cnt_r;
	logic [31:0] dly_cnt_r;
	logic [15:0] win_cnt_r;
	logic win_open;
	logic aux_prev_r;
	logic aux_edge;
	logic [15:0] pac_cnt_r;
	logic aux_lvl_r;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				old[i*8 +: 8] = d[i*8 +: 8];
		return old;
	endfunction

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// Ready held low while frozen so no handshake is lost
	assign s_axi_awready_out = ce_in && !aw_hold_r;
	assign s_axi_wready_out = ce_in && !w_hold_r;
	assign s_axi_arready_out = ce_in && !s_axi_rvalid_out;
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid_out;

	// Address and data captured independently, in either order
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_hold_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end
		else if (ce_in)
		begin
			if (s_axi_awvalid_in && !aw_hold_r)
			begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr_in;
			end
			else if (wr_go)
				aw_hold_r <= 1'b0;
			if (s_axi_wvalid_in && !w_hold_r)
			begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata_in;
				w_strb_r <= s_axi_wstrb_in;
			end
			else if (wr_go)
				w_hold_r <= 1'b0;
		end
	end

	// Write response, one outstanding
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= tta_pkg::RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (wr_go)
			begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_hit ? tta_pkg::RESP_OKAY : tta_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	// Writable offsets; status is read only
	always_comb
	begin
		case (aw_addr_r)
			tta_pkg::OFS_TRIG_CFG, tta_pkg::OFS_TIMEOUT, tta_pkg::OFS_DELAY,
			tta_pkg::OFS_AUX_CFG, tta_pkg::OFS_PACK, tta_pkg::OFS_ACQ: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Read mux, unmapped reads return zero with an error
	always_comb
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr_in)
			tta_pkg::OFS_TRIG_CFG: rd_data = trig_cfg_r;
			tta_pkg::OFS_TIMEOUT: rd_data = timeout_r;
			tta_pkg::OFS_DELAY: rd_data = delay_r;
			tta_pkg::OFS_AUX_CFG: rd_data = aux_cfg_r;
			tta_pkg::OFS_PACK: rd_data = {30'h0, pack_sel_r};
			tta_pkg::OFS_ACQ: rd_data = acq_r;
			tta_pkg::OFS_STATUS: rd_data = {25'h0, armed, sample_packing_select_out, win_open, state_r,
				(aux_mode == tta_pkg::aux_mode_level_in) && aux_lvl_r}; // R14
			default:
			begin
				rd_data = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read data registered, held until rready
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= tta_pkg::RESP_OKAY;
		end
		else if (ce_in)
		begin
			if (s_axi_arvalid_in && !s_axi_rvalid_out)
			begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_data;
				s_axi_rresp_out <= rd_hit ? tta_pkg::RESP_OKAY : tta_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Power-on: trigger output on aux, 16-bit packing, timeout off
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			trig_cfg_r <= tta_pkg::TRIG_CFG_RST;
			timeout_r <= tta_pkg::ZERO_RST;
			delay_r <= tta_pkg::ZERO_RST;
			aux_cfg_r <= tta_pkg::AUX_CFG_RST; // R9
			pack_sel_r <= tta_pkg::packing_sixteen_bit; // R15
			acq_r <= tta_pkg::ZERO_RST;
		end
		else if (ce_in && wr_go)
		begin
			case (aw_addr_r)
				tta_pkg::OFS_TRIG_CFG: trig_cfg_r <= wmerge(trig_cfg_r, w_data_r, w_strb_r) & tta_pkg::TRIG_CFG_MASK;
				tta_pkg::OFS_TIMEOUT: timeout_r <= wmerge(timeout_r, w_data_r, w_strb_r);
				tta_pkg::OFS_DELAY: delay_r <= wmerge(delay_r, w_data_r, w_strb_r);
				tta_pkg::OFS_AUX_CFG: aux_cfg_r <= wmerge(aux_cfg_r, w_data_r, w_strb_r) & tta_pkg::AUX_CFG_MASK;
				tta_pkg::OFS_PACK: if (w_strb_r[0]) pack_sel_r <= w_data_r[1:0];
				tta_pkg::OFS_ACQ: acq_r <= wmerge(acq_r, w_data_r, w_strb_r) & tta_pkg::ACQ_MASK;
				default: ;
			endcase
		end
	end

	assign aux_mode = tta_pkg::tta_aux_e'(aux_cfg_r[2:0]);
	assign aux_param = aux_cfg_r[tta_pkg::F_PARAM_LSB +: 16];
	assign armed = acq_r[0];

	// ----------------------------------------
	// Trigger engines and combining
	// ----------------------------------------
	for (genvar g = 0; g < 2; g++)
	begin : g_eng
		assign eng_cfg[g] = '{src: tta_pkg::tta_src_e'(trig_cfg_r[tta_pkg::F_SRC_LSB + g*tta_pkg::F_ENG_STRIDE +: 2]),
			slope_neg: trig_cfg_r[tta_pkg::F_SLOPE_BIT + g*tta_pkg::F_ENG_STRIDE],
			level: trig_cfg_r[tta_pkg::F_LVL_LSB + g*8 +: 8]};
		tta_trig_engine u_eng (
			.ref_clk_in(ref_clk_in),
			.rst_n_in(rst_n_in),
			.ce_in(ce_in),
			.cfg_in(eng_cfg[g]),
			.ext_code_in(external_trigger_input_in),
			.ch_a_code_in(ch_a_code_in),
			.event_out(eng_ev[g])
		);
	end

	// Board trigger from the selected engine combination
	always_comb
	begin
		case (tta_pkg::tta_op_e'(trig_cfg_r[tta_pkg::F_OP_LSB +: 2]))
			tta_pkg::combine_engine_j: hw_trig = eng_ev[0]; // R3
			tta_pkg::combine_engine_k: hw_trig = eng_ev[1]; // R3
			tta_pkg::combine_either_engine: hw_trig = |eng_ev; // R3
			default: hw_trig = 1'b0;
		endcase
	end

	// Enable window gates both hardware and automatic triggers
	assign gate_ok = (aux_mode != tta_pkg::aux_mode_trig_enable) || win_open; // R13
	assign hw_ok = hw_trig && gate_ok;
	assign to_fire = gate_ok && (timeout_r != 32'h0) && (to_cnt_r == timeout_r); // R4 R5
	assign accept = (state_r == tta_pkg::st_wait) && armed && (hw_ok || to_fire);

	// ----------------------------------------
	// Timeout counter, 10 us ticks
	// ----------------------------------------
	// Restarts when not waiting, on a hardware trigger, or while the window is shut
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tick_cnt_r <= 12'h000;
			to_cnt_r <= 32'h0;
		end
		else if (ce_in)
		begin
			if (state_r != tta_pkg::st_wait || hw_trig || accept || !gate_ok)
			begin
				tick_cnt_r <= 12'h000; // R18
				to_cnt_r <= 32'h0; // R18
			end
			else if (timeout_r != 32'h0 && tick_cnt_r == tta_pkg::TICK_LAST) // R5
			begin
				tick_cnt_r <= 12'h000;
				to_cnt_r <= to_cnt_r + 32'h1;
			end
			else if (timeout_r != 32'h0)
				tick_cnt_r <= tick_cnt_r + 12'h001;
		end
	end

	// ----------------------------------------
	// Acquisition sequencer
	// ----------------------------------------
	// One record per accepted trigger, record_start_out delay_r + 1 sample clocks after trigger_out
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_r <= tta_pkg::st_idle;
			dly_cnt_r <= 32'h0;
		end
		else if (ce_in)
		begin
			case (state_r)
				tta_pkg::st_idle:
					if (armed)
						state_r <= tta_pkg::st_wait;
				tta_pkg::st_wait:
					if (!armed)
						state_r <= tta_pkg::st_idle;
					else if (accept)
					begin
						state_r <= tta_pkg::st_delay;
						dly_cnt_r <= 32'h0;
					end
				tta_pkg::st_delay:
					if (dly_cnt_r >= delay_r)
						state_r <= tta_pkg::st_capt; // R7
					else
						dly_cnt_r <= dly_cnt_r + 32'h1; // R7
				tta_pkg::st_capt:
					state_r <= armed ? tta_pkg::st_wait : tta_pkg::st_idle;
				default:
					state_r <= tta_pkg::st_idle;
			endcase
		end
	end

	assign record_start_out = (state_r == tta_pkg::st_capt);

	// Packing taken only as the acquisition arms; mid-run writes wait
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			sample_packing_select_out <= tta_pkg::packing_sixteen_bit; // R15
		else if (ce_in && state_r == tta_pkg::st_idle && armed)
			sample_packing_select_out <= (pack_sel_r == 2'h3) ? tta_pkg::packing_sixteen_bit : pack_sel_r; // R16 R17
	end

	// ----------------------------------------
	// Trigger enable window
	// ----------------------------------------
	// Edges during an open window are ignored, not queued
	assign aux_edge = aux_param[0] ? (aux_prev_r && !aux_in) : (!aux_prev_r && aux_in);
	assign win_open = (win_cnt_r != 16'h0);

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			aux_prev_r <= 1'b0;
			win_cnt_r <= 16'h0;
		end
		else if (ce_in)
		begin
			aux_prev_r <= aux_in;
			if (!armed || aux_mode != tta_pkg::aux_mode_trig_enable)
				win_cnt_r <= 16'h0;
			else if (!win_open && aux_edge)
				win_cnt_r <= acq_r[tta_pkg::F_RPB_LSB +: 16]; // R13
			else if (accept && win_open)
				win_cnt_r <= win_cnt_r - 16'h1; // R13
		end
	end

	// ----------------------------------------
	// Aux pin drive
	// ----------------------------------------
	// Divider below 3 is not supported; 1 and 2 wrap early, 0 runs the full 16-bit count
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pac_cnt_r <= 16'h0;
		else if (ce_in)
		begin
			if (aux_mode != tta_pkg::aux_mode_pacer || pac_cnt_r >= aux_param - 16'h1) // R11
				pac_cnt_r <= 16'h0;
			else
				pac_cnt_r <= pac_cnt_r + 16'h1; // R10
		end
	end

	// Pin output registered on the sample clock per mode
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			aux_out <= 1'b0;
			aux_oe_out <= 1'b1; // R9
			trigger_out <= 1'b0;
			aux_lvl_r <= 1'b0;
		end
		else if (ce_in)
		begin
			trigger_out <= accept;
			aux_lvl_r <= aux_in; // R14
			case (aux_mode)
				tta_pkg::aux_mode_trig_out:
				begin
					aux_out <= accept; // R8
					aux_oe_out <= 1'b1;
				end
				tta_pkg::aux_mode_pacer:
				begin
					aux_out <= (pac_cnt_r < {1'b0, aux_param[15:1]}); // R10
					aux_oe_out <= 1'b1;
				end
				tta_pkg::aux_mode_static:
				begin
					aux_out <= aux_param[0]; // R12
					aux_oe_out <= 1'b1;
				end
				default:
				begin
					aux_out <= 1'b0;
					aux_oe_out <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	chk_timeout_fire: assert property (ce_in && state_r == tta_pkg::st_wait && armed && to_fire // R4
		|=> state_r == tta_pkg::st_delay) else $error("timeout did not start a record");
	chk_timeout_off: assert property (timeout_r == 32'h0 |-> !to_fire) // R5
		else $error("timeout fired while disabled");
	chk_timeout_clr: assert property (ce_in && hw_trig |=> to_cnt_r == 32'h0) // R18
		else $error("timeout count not cleared by trigger");
	chk_delay_end: assert property (ce_in && state_r == tta_pkg::st_delay && dly_cnt_r < delay_r // R7
		|=> state_r == tta_pkg::st_delay && dly_cnt_r == $past(dly_cnt_r) + 32'h1) else $error("delay cut short");
	chk_combine_sel: assert property (trig_cfg_r[1:0] == 2'h1 |-> hw_trig == eng_ev[1]) // R3
		else $error("engine K selection wrong");
	chk_trig_pin: assert property (ce_in && aux_mode == tta_pkg::aux_mode_trig_out && accept // R8
		|=> aux_out && aux_oe_out && trigger_out) else $error("trigger not on aux pin");
	chk_static_level: assert property (ce_in && aux_mode == tta_pkg::aux_mode_static // R12
		|=> aux_out == $past(aux_param[0]) && aux_oe_out) else $error("static level wrong");
	chk_pacer_range: assert property (aux_mode == tta_pkg::aux_mode_pacer && aux_param > 16'h2 // R10
		|-> pac_cnt_r < aux_param) else $error("pacer count out of range");
	chk_window_gate: assert property (aux_mode == tta_pkg::aux_mode_trig_enable && !win_open // R13
		|-> !accept) else $error("trigger taken with window closed");
	chk_pack_hold: assert property (ce_in && state_r != tta_pkg::st_idle // R17
		|=> $stable(sample_packing_select_out)) else $error("packing changed mid acquisition");
	chk_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write response dropped");

	cov_timeout: cover property (accept && to_fire && !hw_trig);
	cov_window: cover property (win_open && accept);
	cov_capture: cover property (record_start_out && delay_r > 32'h2);
	cov_pacer: cover property (aux_mode == tta_pkg::aux_mode_pacer && $rose(aux_out));

endmodule

/* File: verilog/tta_trig_engine.sv */
// Purpose: One trigger engine, level crossing detector on a selectable 8-bit source
// Assumes: Source codes are unsigned, 128 is zero volts
// Notes: Event is a one-cycle registered pulse
`timescale 1ns/1ps
module tta_trig_engine (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire tta_pkg::tta_eng_cfg_s cfg_in,
	input wire logic [7:0] ext_code_in,
	input wire logic [7:0] ch_a_code_in,
	output logic event_out
);

	logic [7:0] code;
	logic [7:0] prev_r;
	logic valid_r;
	tta_pkg::tta_src_e src_r;

	// Source select, external input is a full source
	always_comb
	begin
		case (cfg_in.src)
			tta_pkg::source_external_input: code = ext_code_in; // R1
			tta_pkg::source_channel_a: code = ch_a_code_in;
			default: code = cfg_in.level;
		endcase
	end

	// Crossing detect; valid_r and src_r block a false edge right after any source change
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			prev_r <= tta_pkg::LEVEL_ZERO_VOLT;
			valid_r <= 1'b0;
			src_r <= tta_pkg::source_none;
			event_out <= 1'b0;
		end
		else if (ce_in)
		begin
			prev_r <= code;
			src_r <= cfg_in.src;
			valid_r <= (cfg_in.src != tta_pkg::source_none);
			if (!valid_r || cfg_in.src == tta_pkg::source_none || cfg_in.src != src_r)
				event_out <= 1'b0;
			else if (cfg_in.slope_neg)
				event_out <= (prev_r >= cfg_in.level) && (code < cfg_in.level); // R2
			else
				event_out <= (prev_r <= cfg_in.level) && (code > cfg_in.level); // R2
		end
	end

endmodule
